/* rtl/aim_regs.sv */
`timescale 1ns/100ps
`include "aim_cfg.svh"

module aim_regs (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic reset_in,
    // axi4-lite write address
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [`AIM_ADDR_W-1:0] s_axi_awaddr_in,
    input wire logic [2:0] s_axi_awprot_in,
    // axi4-lite write data
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    input wire logic [`AIM_DATA_W-1:0] s_axi_wdata_in,
    input wire logic [`AIM_STRB_W-1:0] s_axi_wstrb_in,
    // axi4-lite write response
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    output logic [1:0] s_axi_bresp_out,
    // axi4-lite read address
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    input wire logic [`AIM_ADDR_W-1:0] s_axi_araddr_in,
    input wire logic [2:0] s_axi_arprot_in,
    // axi4-lite read data
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    output logic [`AIM_DATA_W-1:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    // conversion engine events, one bit per analog_channel
    input wire logic [`AIM_NUM_IN-1:0] conv_done_in,
    input wire logic [`AIM_NUM_IN-1:0] data_read_in,
    // per-input mode selects, index 0 is analog_channel 16
    output logic [`AIM_MODE_IN-1:0] balanced_input_select_out,
    output logic [`AIM_MODE_IN-1:0] result_signed_out,
    // converter interrupt request
    output logic adc_irq_out
);

    aim_pkg::aim_state_t st_ff;
    aim_pkg::aim_state_t nxt_st;
    logic [`AIM_MODE_B_W+`AIM_MODE_C_W-1:0] mode_all;
    logic [`AIM_NUM_IN-1:0] en_all;

    // ==========================================
    // address decode
    function automatic aim_pkg::aim_reg_t decode(input logic [`AIM_ADDR_W-1:0] a);
        case (a)
            `AIM_OFS_MODE_B: decode = aim_pkg::AIM_R_MODE_B;
            `AIM_OFS_MODE_C: decode = aim_pkg::AIM_R_MODE_C;
            `AIM_OFS_EN_LO: decode = aim_pkg::AIM_R_EN_LO;
            `AIM_OFS_EN_HI: decode = aim_pkg::AIM_R_EN_HI;
            `AIM_OFS_RDY_LO: decode = aim_pkg::AIM_R_RDY_LO;
            `AIM_OFS_RDY_HI: decode = aim_pkg::AIM_R_RDY_HI;
            default: decode = aim_pkg::AIM_R_NONE;
        endcase
    endfunction

    // byte-lane merge of a write into an old value
    function automatic logic [`AIM_DATA_W-1:0] merge(
        input logic [`AIM_DATA_W-1:0] old_v,
        input logic [`AIM_DATA_W-1:0] new_v,
        input logic [`AIM_STRB_W-1:0] strb
    );
        logic [`AIM_DATA_W-1:0] r;
        r = old_v;
        for (int b = 0; b < `AIM_STRB_W; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        merge = r;
    endfunction

    // ==========================================
    // mode bit fan-out, two bits per input
    assign mode_all = {st_ff.mode_c, st_ff.mode_b};
    assign en_all = {st_ff.en_hi, st_ff.en_lo};

    for (genvar i = 0; i < `AIM_MODE_IN; i++) begin : g_mode
        assign balanced_input_select_out[i] = mode_all[2*i+1];
        assign result_signed_out[i] = mode_all[2*i];
    end

    // ==========================================
    // bus-facing outputs straight from the state
    assign s_axi_awready_out = st_ff.awready;
    assign s_axi_wready_out = st_ff.wready;
    assign s_axi_bvalid_out = st_ff.bvalid;
    assign s_axi_bresp_out = st_ff.bresp;
    assign s_axi_arready_out = st_ff.arready;
    assign s_axi_rvalid_out = st_ff.rvalid;
    assign s_axi_rdata_out = st_ff.rdata;
    assign s_axi_rresp_out = st_ff.rresp;
    assign adc_irq_out = st_ff.irq;

    // ==========================================
    // next-state logic
    always_comb begin
        logic aw_hs;
        logic w_hs;
        logic [`AIM_DATA_W-1:0] wd;
        aim_pkg::aim_reg_t wsel;
        aim_pkg::aim_reg_t rsel;
        nxt_st = st_ff;
        aw_hs = s_axi_awvalid_in && st_ff.awready;
        w_hs = s_axi_wvalid_in && st_ff.wready;
        wd = '0;
        wsel = aim_pkg::AIM_R_NONE;
        rsel = decode(s_axi_araddr_in);

        // ready flags: a new result beats a read in the same cycle
        nxt_st.rdy = (st_ff.rdy & ~data_read_in) | conv_done_in;

        // interrupt is any enabled input with data waiting
        nxt_st.irq = |(en_all & st_ff.rdy);

        // write address and data caught in either order
        if (aw_hs) begin
            nxt_st.aw_got = 1'b1;
            nxt_st.waddr = s_axi_awaddr_in;
        end
        if (w_hs) begin
            nxt_st.w_got = 1'b1;
            nxt_st.wdata = s_axi_wdata_in;
            nxt_st.wstrb = s_axi_wstrb_in;
        end

        case (st_ff.wst)
            aim_pkg::AIM_WR_IDLE: begin
                if (nxt_st.aw_got && nxt_st.w_got) begin
                    wsel = decode(nxt_st.waddr);
                    nxt_st.bresp = `AIM_RESP_OKAY;
                    case (wsel)
                        aim_pkg::AIM_R_MODE_B: begin
                            nxt_st.mode_b = merge(st_ff.mode_b, nxt_st.wdata,
                                nxt_st.wstrb);
                        end
                        aim_pkg::AIM_R_MODE_C: begin
                            wd = merge({8'h00, st_ff.mode_c}, nxt_st.wdata, nxt_st.wstrb);
                            nxt_st.mode_c = wd[`AIM_MODE_C_W-1:0];
                        end
                        aim_pkg::AIM_R_EN_LO: begin
                            nxt_st.en_lo = merge(st_ff.en_lo, nxt_st.wdata,
                                nxt_st.wstrb);
                        end
                        aim_pkg::AIM_R_EN_HI: begin
                            wd = merge({20'h0_0000, st_ff.en_hi}, nxt_st.wdata, nxt_st.wstrb);
                            nxt_st.en_hi = wd[`AIM_EN_HI_W-1:0];
                        end
                        aim_pkg::AIM_R_RDY_LO, aim_pkg::AIM_R_RDY_HI: begin
                            // status is read-only, write has no effect
                        end
                        default: begin
                            nxt_st.bresp = `AIM_RESP_SLVERR;
                        end
                    endcase
                    nxt_st.aw_got = 1'b0;
                    nxt_st.w_got = 1'b0;
                    nxt_st.bvalid = 1'b1;
                    nxt_st.wst = aim_pkg::AIM_WR_RESP;
                end
            end
            aim_pkg::AIM_WR_RESP: begin
                if (s_axi_bready_in) begin
                    nxt_st.bvalid = 1'b0;
                    nxt_st.wst = aim_pkg::AIM_WR_IDLE;
                end
            end
            default: begin
                nxt_st.wst = aim_pkg::AIM_WR_IDLE;
            end
        endcase

        // channel readies reopen only while no response is pending
        nxt_st.awready = (nxt_st.wst == aim_pkg::AIM_WR_IDLE) && !nxt_st.aw_got;
        nxt_st.wready = (nxt_st.wst == aim_pkg::AIM_WR_IDLE) && !nxt_st.w_got;

        // read sequencer
        case (st_ff.rst)
            aim_pkg::AIM_RD_IDLE: begin
                if (s_axi_arvalid_in && st_ff.arready) begin
                    nxt_st.rresp = `AIM_RESP_OKAY;
                    case (rsel)
                        aim_pkg::AIM_R_MODE_B: nxt_st.rdata = st_ff.mode_b;
                        aim_pkg::AIM_R_MODE_C: nxt_st.rdata = {8'h00, st_ff.mode_c};
                        aim_pkg::AIM_R_EN_LO: nxt_st.rdata = st_ff.en_lo;
                        aim_pkg::AIM_R_EN_HI: nxt_st.rdata = {20'h0_0000, st_ff.en_hi};
                        aim_pkg::AIM_R_RDY_LO: nxt_st.rdata = st_ff.rdy[31:0];
                        aim_pkg::AIM_R_RDY_HI: nxt_st.rdata = {20'h0_0000, st_ff.rdy[43:32]};
                        default: begin
                            nxt_st.rdata = '0;
                            nxt_st.rresp = `AIM_RESP_SLVERR;
                        end
                    endcase
                    nxt_st.arready = 1'b0;
                    nxt_st.rvalid = 1'b1;
                    nxt_st.rst = aim_pkg::AIM_RD_DATA;
                end
            end
            aim_pkg::AIM_RD_DATA: begin
                if (s_axi_rready_in) begin
                    nxt_st.rvalid = 1'b0;
                    nxt_st.arready = 1'b1;
                    nxt_st.rst = aim_pkg::AIM_RD_IDLE;
                end
            end
            default: begin
                nxt_st.rst = aim_pkg::AIM_RD_IDLE;
            end
        endcase

        // read address channel open whenever no read data is pending; low during reset, opens at the first edge after it
        nxt_st.arready = (nxt_st.rst == aim_pkg::AIM_RD_IDLE);
    end

    // ==========================================
    // state register, everything clears at reset
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ==========================================
    // checks on the register slice

    // interrupt tracks enabled ready flags one cycle later
    irq_follows_a: assert property (
        @(posedge sys_clk_in) disable iff (reset_in)
        (|(en_all & st_ff.rdy)) |=> adc_irq_out
    ) else $error("interrupt missing for enabled ready input");

    // no enabled pending input, no interrupt
    irq_masked_a: assert property (
        @(posedge sys_clk_in) disable iff (reset_in)
        ((en_all & st_ff.rdy) == '0) |=> !adc_irq_out
    ) else $error("interrupt raised without enabled ready input");

    // a completed conversion always sets its flag
    rdy_set_a: assert property (
        @(posedge sys_clk_in) disable iff (reset_in)
        (conv_done_in != '0) |=> ((st_ff.rdy & $past(conv_done_in)) == $past(conv_done_in))
    ) else $error("ready flag not set by conversion");

    // a data read clears its flag unless a new result lands
    rdy_clear_a: assert property (
        @(posedge sys_clk_in) disable iff (reset_in)
        ((data_read_in & ~conv_done_in) != '0)
        |=> ((st_ff.rdy & $past(data_read_in & ~conv_done_in)) == '0)
    ) else $error("ready flag not cleared by data read");

    // unimplemented top of input_mode_ctl_c reads zero
    mode_c_top_a: assert property (
        @(posedge sys_clk_in) disable iff (reset_in)
        (s_axi_arvalid_in && s_axi_arready_out && s_axi_araddr_in == `AIM_OFS_MODE_C)
        |=> (s_axi_rvalid_out && s_axi_rdata_out[31:24] == 8'h00)
    ) else $error("mode register c upper bits not zero");

    // unimplemented top of sample_irq_enable_hi reads zero
    en_hi_top_a: assert property (
        @(posedge sys_clk_in) disable iff (reset_in)
        (s_axi_arvalid_in && s_axi_arready_out && s_axi_araddr_in == `AIM_OFS_EN_HI)
        |=> (s_axi_rvalid_out && s_axi_rdata_out[31:12] == 20'h0_0000)
    ) else $error("enable register hi upper bits not zero");

    // full write of input_mode_ctl_b lands on the select outputs
    mode_b_write_a: assert property (
        @(posedge sys_clk_in) disable iff (reset_in)
        (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out
            && s_axi_awaddr_in == `AIM_OFS_MODE_B && s_axi_wstrb_in == 4'hF)
        |=> (s_axi_bvalid_out && balanced_input_select_out[15] == $past(s_axi_wdata_in[31])
            && result_signed_out[15] == $past(s_axi_wdata_in[30])
            && result_signed_out[0] == $past(s_axi_wdata_in[0]))
    ) else $error("mode register b write not reflected");

    // full write of sample_irq_enable_lo lands in the enables unchanged
    en_lo_write_a: assert property (
        @(posedge sys_clk_in) disable iff (reset_in)
        (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out
            && s_axi_awaddr_in == `AIM_OFS_EN_LO && s_axi_wstrb_in == 4'hF)
        |=> (en_all[31:0] == $past(s_axi_wdata_in))
    ) else $error("enable register lo write lost");

    // read data and valid hold until taken
    rdata_hold_a: assert property (
        @(posedge sys_clk_in) disable iff (reset_in)
        (s_axi_rvalid_out && !s_axi_rready_in) |=> (s_axi_rvalid_out && $stable(s_axi_rdata_out))
    ) else $error("read data dropped before taken");

    // write response holds until taken
    bresp_hold_a: assert property (
        @(posedge sys_clk_in) disable iff (reset_in)
        (s_axi_bvalid_out && !s_axi_bready_in) |=> s_axi_bvalid_out ##0 $stable(s_axi_bresp_out)
    ) else $error("write response dropped before taken");

    // full write of input_mode_ctl_c lands on the select outputs
    mode_c_write_a: assert property (
        @(posedge sys_clk_in) disable iff (reset_in)
        (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out
            && s_axi_awaddr_in == `AIM_OFS_MODE_C && s_axi_wstrb_in == 4'hF)
        |=> (s_axi_bvalid_out && balanced_input_select_out[27] == $past(s_axi_wdata_in[23])
            && result_signed_out[27] == $past(s_axi_wdata_in[22])
            && balanced_input_select_out[16] == $past(s_axi_wdata_in[1]))
    ) else $error("mode register c write not reflected");

    // full write of sample_irq_enable_hi lands in the enables
    en_hi_write_a: assert property (
        @(posedge sys_clk_in) disable iff (reset_in)
        (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out
            && s_axi_awaddr_in == `AIM_OFS_EN_HI && s_axi_wstrb_in == 4'hF)
        |=> (en_all[43:32] == $past(s_axi_wdata_in[11:0]))
    ) else $error("enable register hi write lost");

    // a set flag stays set until its data is read
    rdy_hold_a: assert property (
        @(posedge sys_clk_in) disable iff (reset_in)
        ((st_ff.rdy & ~data_read_in) != '0)
        |=> ((st_ff.rdy & $past(st_ff.rdy & ~data_read_in))
            == $past(st_ff.rdy & ~data_read_in))
    ) else $error("ready flag lost without data read");

    // read address channel reopens once read data is taken
    ar_reopen_a: assert property (
        @(posedge sys_clk_in) disable iff (reset_in)
        $fell(s_axi_rvalid_out) |-> s_axi_arready_out
    ) else $error("read address ready not restored");

endmodule

/* rtl/aim_cfg.svh */
`ifndef AIM_CFG_SVH
`define AIM_CFG_SVH

// ==========================================
// bus geometry
`define AIM_ADDR_W 8
`define AIM_DATA_W 32
`define AIM_STRB_W 4

// ==========================================
// register byte offsets
`define AIM_OFS_MODE_B 8'h00
`define AIM_OFS_MODE_C 8'h04
`define AIM_OFS_EN_LO 8'h08
`define AIM_OFS_EN_HI 8'h0C
`define AIM_OFS_RDY_LO 8'h10
`define AIM_OFS_RDY_HI 8'h14

// ==========================================
// field widths and implemented-bit counts
`define AIM_MODE_B_W 32
`define AIM_MODE_C_W 24
`define AIM_EN_LO_W 32
`define AIM_EN_HI_W 12
`define AIM_NUM_IN 44
`define AIM_MODE_IN 28
`define AIM_MODE_B_IN 16
`define AIM_FIRST_MODE_IN 16

// ==========================================
// reset values
`define AIM_RST_MODE_B 32'h0000_0000
`define AIM_RST_MODE_C 24'h00_0000
`define AIM_RST_EN_LO 32'h0000_0000
`define AIM_RST_EN_HI 12'h000
`define AIM_RST_RDY 44'h000_0000_0000

// ==========================================
// bus response codes
`define AIM_RESP_OKAY 2'h0
`define AIM_RESP_SLVERR 2'h2

`endif

/* rtl/aim_pkg.sv */
`include "aim_cfg.svh"

package aim_pkg;

    // write channel sequencer
    typedef enum logic [0:0] {
        AIM_WR_IDLE,
        AIM_WR_RESP
    } aim_wr_st_t;

    // read channel sequencer
    typedef enum logic [0:0] {
        AIM_RD_IDLE,
        AIM_RD_DATA
    } aim_rd_st_t;

    // register selected by an address
    typedef enum logic [2:0] {
        AIM_R_MODE_B,
        AIM_R_MODE_C,
        AIM_R_EN_LO,
        AIM_R_EN_HI,
        AIM_R_RDY_LO,
        AIM_R_RDY_HI,
        AIM_R_NONE
    } aim_reg_t;

    // whole state of the register slice
    typedef struct packed {
        logic [`AIM_MODE_B_W-1:0] mode_b;
        logic [`AIM_MODE_C_W-1:0] mode_c;
        logic [`AIM_EN_LO_W-1:0] en_lo;
        logic [`AIM_EN_HI_W-1:0] en_hi;
        logic [`AIM_NUM_IN-1:0] rdy;
        logic irq;
        aim_wr_st_t wst;
        logic aw_got;
        logic w_got;
        logic [`AIM_ADDR_W-1:0] waddr;
        logic [`AIM_DATA_W-1:0] wdata;
        logic [`AIM_STRB_W-1:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        aim_rd_st_t rst;
        logic arready;
        logic rvalid;
        logic [`AIM_DATA_W-1:0] rdata;
        logic [1:0] rresp;
    } aim_state_t;

endpackage

/* verification/tb_aim_regs.sv */
`timescale 1ns/100ps
`include "aim_cfg.svh"

module tb_aim_regs;

    // ==========================================
    // design inputs, all defined at time zero
    logic sys_clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic s_axi_awvalid_in = 1'b0;
    logic [7:0] s_axi_awaddr_in = 8'h00;
    logic s_axi_wvalid_in = 1'b0;
    logic [31:0] s_axi_wdata_in = 32'h0000_0000;
    logic [3:0] s_axi_wstrb_in = 4'h0;
    logic s_axi_bready_in = 1'b0;
    logic s_axi_arvalid_in = 1'b0;
    logic [7:0] s_axi_araddr_in = 8'h00;
    logic s_axi_rready_in = 1'b0;
    logic [43:0] conv_done_in = 44'h000_0000_0000;
    logic [43:0] data_read_in = 44'h000_0000_0000;
    logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
    logic s_axi_arready_out, s_axi_rvalid_out, adc_irq_out;
    logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
    logic [31:0] s_axi_rdata_out;
    logic [27:0] balanced_input_select_out, result_signed_out;
    int fail_count = 0;
    int n_compared = 0;

    // ==========================================
    // table of register rows: address, data, strobes, readback, response
    typedef struct {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic [3:0] strb;
        logic [31:0] rexp;
        logic [1:0] resp;
    } aim_row_t;
    aim_row_t rows[9] = '{
        '{8'h00, 32'hFFFF_FFFF, 4'hF, 32'hFFFF_FFFF, 2'h0},
        '{8'h00, 32'h1234_5678, 4'h1, 32'hFFFF_FF78, 2'h0},
        '{8'h04, 32'hFFFF_FFFF, 4'hF, 32'h00FF_FFFF, 2'h0},
        '{8'h04, 32'h0055_5555, 4'hF, 32'h0055_5555, 2'h0},
        '{8'h08, 32'hA5A5_A5A5, 4'hF, 32'hA5A5_A5A5, 2'h0},
        '{8'h0C, 32'hFFFF_FFFF, 4'hF, 32'h0000_0FFF, 2'h0},
        '{8'h10, 32'hFFFF_FFFF, 4'hF, 32'h0000_0000, 2'h0},
        '{8'h18, 32'hFFFF_FFFF, 4'hF, 32'h0000_0000, 2'h2},
        '{8'h00, 32'hAAAA_AAAA, 4'hC, 32'hAAAA_FF78, 2'h0}
    };
    logic [31:0] sh_b = 32'h0000_0000;
    logic [31:0] sh_c = 32'h0000_0000;
    logic [31:0] rd;
    logic [1:0] rsp;

    // ==========================================
    // clock and device under test
    initial begin
        forever #12.5 sys_clk_in = ~sys_clk_in;
    end

    aim_regs aim_regs_inst (
        .sys_clk_in(sys_clk_in), .reset_in(reset_in),
        .s_axi_awvalid_in(s_axi_awvalid_in), .s_axi_awready_out(s_axi_awready_out),
        .s_axi_awaddr_in(s_axi_awaddr_in), .s_axi_awprot_in(3'h0),
        .s_axi_wvalid_in(s_axi_wvalid_in), .s_axi_wready_out(s_axi_wready_out),
        .s_axi_wdata_in(s_axi_wdata_in), .s_axi_wstrb_in(s_axi_wstrb_in),
        .s_axi_bvalid_out(s_axi_bvalid_out), .s_axi_bready_in(s_axi_bready_in),
        .s_axi_bresp_out(s_axi_bresp_out),
        .s_axi_arvalid_in(s_axi_arvalid_in), .s_axi_arready_out(s_axi_arready_out),
        .s_axi_araddr_in(s_axi_araddr_in), .s_axi_arprot_in(3'h0),
        .s_axi_rvalid_out(s_axi_rvalid_out), .s_axi_rready_in(s_axi_rready_in),
        .s_axi_rdata_out(s_axi_rdata_out), .s_axi_rresp_out(s_axi_rresp_out),
        .conv_done_in(conv_done_in), .data_read_in(data_read_in),
        .balanced_input_select_out(balanced_input_select_out),
        .result_signed_out(result_signed_out), .adc_irq_out(adc_irq_out)
    );

    // ==========================================
    // shared tasks: compare, reset, bus cycles, event pulses
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic do_reset();
        @(posedge sys_clk_in);
        reset_in <= 1'b1;
        repeat (16) @(posedge sys_clk_in);
        reset_in <= 1'b0;
    endtask

    // write address and data offered together, each released when taken
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                             output logic [1:0] r);
        logic aw_done;
        logic w_done;
        logic got;
        aw_done = 1'b0;
        w_done = 1'b0;
        got = 1'b0;
        @(posedge sys_clk_in);
        s_axi_awvalid_in <= 1'b1;
        s_axi_awaddr_in <= a;
        s_axi_wvalid_in <= 1'b1;
        s_axi_wdata_in <= d;
        s_axi_wstrb_in <= s;
        s_axi_bready_in <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge sys_clk_in);
            if (s_axi_awvalid_in && s_axi_awready_out) begin
                s_axi_awvalid_in <= 1'b0;
                aw_done = 1'b1;
            end
            if (s_axi_wvalid_in && s_axi_wready_out) begin
                s_axi_wvalid_in <= 1'b0;
                w_done = 1'b1;
            end
        end
        while (!got) begin
            @(posedge sys_clk_in);
            if (s_axi_bvalid_out === 1'b1) begin
                r = s_axi_bresp_out;
                s_axi_bready_in <= 1'b0;
                got = 1'b1;
            end
        end
    endtask

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic got;
        got = 1'b0;
        @(posedge sys_clk_in);
        s_axi_arvalid_in <= 1'b1;
        s_axi_araddr_in <= a;
        s_axi_rready_in <= 1'b1;
        while (!got) begin
            @(posedge sys_clk_in);
            if (s_axi_arvalid_in && s_axi_arready_out) begin
                s_axi_arvalid_in <= 1'b0;
            end
            if (s_axi_rvalid_out === 1'b1) begin
                d = s_axi_rdata_out;
                r = s_axi_rresp_out;
                s_axi_rready_in <= 1'b0;
                got = 1'b1;
            end
        end
    endtask

    // one-cycle event on input k; returns at the edge that samples it
    task automatic pulse(input int k, input logic d, input logic c);
        @(posedge sys_clk_in);
        conv_done_in[k] <= d;
        data_read_in[k] <= c;
        @(posedge sys_clk_in);
        conv_done_in <= 44'h000_0000_0000;
        data_read_in <= 44'h000_0000_0000;
    endtask

    // expected mode outputs: sel 1 picks the balanced bit, 0 the format bit
    function automatic logic [31:0] mode_exp(input logic [31:0] b, input logic [31:0] c,
                                             input int sel);
        logic [31:0] v;
        v = 32'h0000_0000;
        for (int i = 0; i < 28; i++) begin
            v[i] = (i < 16) ? b[2 * i + sel] : c[2 * (i - 16) + sel];
        end
        return v;
    endfunction

    task automatic give_verdict();
        if (fail_count == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ==========================================
    // watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge sys_clk_in);
        fail_count++;
        give_verdict();
    end

    // ==========================================
    // main sequence
    initial begin
        do_reset();
        // reset values of all six words
        for (int i = 0; i < 6; i++) begin
            axi_read(8'(4 * i), rd, rsp);
            chk(rd, 32'h0000_0000);
        end
        chk({4'h0, balanced_input_select_out}, 32'h0000_0000);
        // table rows: write, read back, check responses and mode outputs
        foreach (rows[i]) begin
            axi_write(rows[i].addr, rows[i].wdata, rows[i].strb, rsp);
            chk({30'h0, rsp}, {30'h0, rows[i].resp});
            axi_read(rows[i].addr, rd, rsp);
            chk(rd, rows[i].rexp);
            chk({30'h0, rsp}, {30'h0, rows[i].resp});
            if (rows[i].addr == 8'h00) sh_b = rows[i].rexp;
            if (rows[i].addr == 8'h04) sh_c = rows[i].rexp;
            chk({4'h0, balanced_input_select_out}, mode_exp(sh_b, sh_c, 1));
            chk({4'h0, result_signed_out}, mode_exp(sh_b, sh_c, 0));
        end
        // enabled input 5: interrupt one cycle after the flag
        pulse(5, 1'b1, 1'b0);
        @(posedge sys_clk_in);
        chk({31'h0, adc_irq_out}, 32'h0000_0000);
        @(posedge sys_clk_in);
        chk({31'h0, adc_irq_out}, 32'h0000_0001);
        // disabled input 6 sets its flag but adds no request
        pulse(6, 1'b1, 1'b0);
        axi_read(8'h10, rd, rsp);
        chk(rd, 32'h0000_0060);
        pulse(5, 1'b0, 1'b1);
        repeat (2) @(posedge sys_clk_in);
        chk({31'h0, adc_irq_out}, 32'h0000_0000);
        axi_read(8'h10, rd, rsp);
        chk(rd, 32'h0000_0040);
        // input 43: set and clear together, set wins
        pulse(43, 1'b1, 1'b1);
        repeat (2) @(posedge sys_clk_in);
        chk({31'h0, adc_irq_out}, 32'h0000_0001);
        axi_read(8'h14, rd, rsp);
        chk(rd, 32'h0000_0800);
        pulse(43, 1'b0, 1'b1);
        repeat (2) @(posedge sys_clk_in);
        chk({31'h0, adc_irq_out}, 32'h0000_0000);
        // second reset in mid-run clears everything again
        do_reset();
        axi_read(8'h00, rd, rsp);
        chk(rd, 32'h0000_0000);
        axi_read(8'h0C, rd, rsp);
        chk(rd, 32'h0000_0000);
        chk({4'h0, result_signed_out}, 32'h0000_0000);
        give_verdict();
    end

endmodule
